// [mcr_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
module mcr_ctrl
  import mcr_pkg::*;
#(
  parameter logic [7:0] OP_EVT_BOTH = 8'h01, // arbitrary value
  parameter logic [7:0] OP_EVT_FLOW = 8'h02, // arbitrary value
  parameter logic [7:0] OP_EVT_TEMP = 8'h03, // arbitrary value
  parameter logic [7:0] OP_HALT     = 8'h04, // arbitrary value
  parameter int         IRQ_N       = 4,
  parameter int         DIV         = SLOW_DIV
) (
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  input  wire mcr_cmd_t         cmd_i,
  input  wire logic             cmp_raw_i,
  input  wire logic             dir_up_i,
  input  wire logic [IRQ_N-1:0] irq_src_i,
  input  wire logic             seq_done_i,
  output logic [15:0]           rd_data_o,
  output logic                  rd_valid_o,
  output logic                  comparator_direction_pin_o,
  output logic                  int_pin_o,
  output logic                  fast_osc_en_o,
  output logic                  flow_seq_start_o,
  output logic                  temp_seq_start_o,
  output logic                  per_cycle_irq_o,
  output logic                  busy_o
);

  // ----------------------------------------------------------------
  // state, one packed word
  // ----------------------------------------------------------------
  // the comb block fills a copy of this and the flop stage takes it
  typedef struct packed {
    logic [15:0] ctrl;
    mcr_state_t  fsm;
    mcr_kind_t   kind;
    logic        temp_phase;
    logic        cmp_s1;
    logic        cmp_s2;
    logic        pin;
    logic        irq;
    logic        osc;
    logic        flow_go;
    logic        temp_go;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        cyc_irq;
    logic        busy;
  } mcr_ctrl_st_t;

  mcr_ctrl_st_t st_ff;
  mcr_ctrl_st_t nxt_st;
  logic         settle_start;
  logic         settle_abort;
  logic         settle_done;
  logic         osc_always;
  logic         evt_cmd;
  logic         wr_cmd;
  logic         rd_cmd;
  logic         halt_cmd;

  // ----------------------------------------------------------------
  // fast oscillator settling timer
  // ----------------------------------------------------------------
  mcr_settle_timer #(
    .DIV(DIV)
  ) u_settle (
    .ref_clk_i(ref_clk_i),
    .resetn_i (resetn_i),
    .start_i  (settle_start),
    .abort_i  (settle_abort),
    .code_i   (st_ff.ctrl[SETTLE_MSB:SETTLE_LSB]),
    .done_o   (settle_done)
  );

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // codes at or above the always-on code keep the oscillator up
  assign osc_always = st_ff.ctrl[SETTLE_MSB:SETTLE_LSB] >= SETTLE_ON;
  assign evt_cmd    = cmd_i.valid &&
                      (cmd_i.opcode == OP_EVT_BOTH ||
                       cmd_i.opcode == OP_EVT_FLOW ||
                       cmd_i.opcode == OP_EVT_TEMP);
  // one decoder feeds both the register and the sequencer paths
  assign wr_cmd     = cmd_i.valid && cmd_i.opcode == MCR_WR_OP;
  assign rd_cmd     = cmd_i.valid && cmd_i.opcode == MCR_RD_OP;
  assign halt_cmd   = cmd_i.valid && cmd_i.opcode == OP_HALT;

  // ----------------------------------------------------------------
  // register access, pins and sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.flow_go  = 1'b0;
    nxt_st.temp_go  = 1'b0;
    nxt_st.rd_valid = 1'b0;
    settle_start    = 1'b0;
    settle_abort    = 1'b0;

    // write masks reserved bits so they read back zero
    if (wr_cmd) begin
      nxt_st.ctrl = cmd_i.data & MCR_WR_MASK;
    end
    if (rd_cmd) begin
      nxt_st.rd_data  = st_ff.ctrl;
      nxt_st.rd_valid = 1'b1;
    end

    // comparator pin is asynchronous: two-stage sync first
    nxt_st.cmp_s1 = cmp_raw_i;
    nxt_st.cmp_s2 = st_ff.cmp_s1;
    // a disabled pin is forced low whatever the source select says
    if (st_ff.ctrl[PIN_EN_BIT]) begin
      nxt_st.pin = st_ff.ctrl[PIN_SEL_BIT] ? st_ff.cmp_s2
                                           : dir_up_i;
    end else begin
      nxt_st.pin = 1'b0;
    end
    // sources are ORed first, then gated by the enable bit
    nxt_st.irq     = st_ff.ctrl[INT_EN_BIT] & (|irq_src_i);
    // per-cycle interrupt bit is only exported, no logic behind it
    nxt_st.cyc_irq = st_ff.ctrl[CYC_IRQ_BIT];

    // event commands are taken only in idle, so they drop while busy
    case (st_ff.fsm)
      ST_IDLE: begin
        if (evt_cmd) begin
          nxt_st.temp_phase = 1'b0;
          case (cmd_i.opcode)
            OP_EVT_FLOW: nxt_st.kind = KIND_FLOW;
            OP_EVT_TEMP: nxt_st.kind = KIND_TEMP;
            default:     nxt_st.kind = KIND_BOTH;
          endcase
          nxt_st.osc   = 1'b1;
          nxt_st.busy  = 1'b1;
          settle_start = 1'b1;
          nxt_st.fsm   = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // nothing is measured until the oscillator has settled
        if (settle_done) begin
          nxt_st.fsm = ST_ISSUE;
        end
      end
      // one start pulse per sequence; the engine answers with done
      ST_ISSUE: begin
        if (st_ff.kind == KIND_TEMP || st_ff.temp_phase) begin
          nxt_st.temp_go = 1'b1;
        end else begin
          nxt_st.flow_go = 1'b1;
        end
        nxt_st.fsm = ST_WAIT;
      end
      // repeats go straight back to issue, the oscillator is still up
      ST_WAIT: begin
        if (seq_done_i) begin
          if (st_ff.kind == KIND_BOTH && !st_ff.temp_phase) begin
            nxt_st.temp_phase = 1'b1;
            nxt_st.fsm        = ST_ISSUE;
          end else if (st_ff.ctrl[REPEAT_BIT]) begin
            nxt_st.temp_phase = 1'b0;
            nxt_st.fsm        = ST_ISSUE;
          end else begin
            nxt_st.busy = 1'b0;
            nxt_st.fsm  = ST_IDLE;
          end
        end
      end
      default: begin
        nxt_st.fsm = ST_IDLE;
      end
    endcase

    // halt ends any running command, in any state
    // a start raised in the issue cycle must not outlive the halt
    if (halt_cmd) begin
      settle_abort   = 1'b1;
      nxt_st.busy    = 1'b0;
      nxt_st.fsm     = ST_IDLE;
      nxt_st.flow_go = 1'b0;
      nxt_st.temp_go = 1'b0;
    end

    // oscillator stays on while busy or when held on by code
    nxt_st.osc = osc_always | nxt_st.busy;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // synchronous reset; register reads back its reset value
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st_ff      <= '0;
      st_ff.ctrl <= MCR_RST_VAL;
      st_ff.fsm  <= ST_IDLE;
      st_ff.kind <= KIND_BOTH;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  assign rd_data_o                  = st_ff.rd_data;
  assign rd_valid_o                 = st_ff.rd_valid;
  assign comparator_direction_pin_o = st_ff.pin;
  assign int_pin_o                  = st_ff.irq;
  assign fast_osc_en_o              = st_ff.osc;
  assign flow_seq_start_o           = st_ff.flow_go;
  assign temp_seq_start_o           = st_ff.temp_go;
  assign per_cycle_irq_o            = st_ff.cyc_irq;
  assign busy_o                     = st_ff.busy;

endmodule
`default_nettype wire

// [mcr_ctrl_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module mcr_ctrl_checker
  import mcr_pkg::*;
#(
  parameter logic [7:0] OP_HALT = 8'h04,
  parameter int         IRQ_N   = 4,
  parameter int         DIV     = SLOW_DIV
) (
  input wire logic             ref_clk_i,
  input wire logic             resetn_i,
  input wire mcr_cmd_t         cmd_i,
  input wire logic             dir_up_i,
  input wire logic [IRQ_N-1:0] irq_src_i,
  input wire logic             rd_valid_o,
  input wire logic             comparator_direction_pin_o,
  input wire logic             int_pin_o,
  input wire logic             fast_osc_en_o,
  input wire logic             flow_seq_start_o,
  input wire logic             temp_seq_start_o,
  input wire logic             busy_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // ------------------------------
  // helpers and properties
  // ------------------------------
  localparam int NS [5] = '{16, 48, 96, 128, 168};
  logic       wr;
  logic       st;
  logic [2:0] code_ff;
  int         up_ff;
  assign wr = cmd_i.valid && cmd_i.opcode == MCR_WR_OP;
  assign st = flow_seq_start_o || temp_seq_start_o;
  // settle field copy and cycles with the fast osc up
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      code_ff <= 3'h0;
      up_ff   <= 0;
    end else begin
      if (wr) code_ff <= cmd_i.data[SETTLE_MSB:SETTLE_LSB];
      up_ff <= fast_osc_en_o ? up_ff + 1 : 0;
    end
  end
  AST_PIN_LOW: assert property (
    wr && !cmd_i.data[PIN_EN_BIT] |-> ##3 !comparator_direction_pin_o)
    else $error("pin not low while disabled");
  AST_PIN_DIR: assert property (
    wr && cmd_i.data[PIN_EN_BIT] && !cmd_i.data[PIN_SEL_BIT]
    |-> ##3 comparator_direction_pin_o == dir_up_i)
    else $error("pin does not follow direction");
  AST_INT_SRC: assert property (
    int_pin_o |-> $past(|irq_src_i))
    else $error("interrupt without source");
  AST_INT_OFF: assert property (
    wr && !cmd_i.data[INT_EN_BIT] |-> ##3 !int_pin_o)
    else $error("interrupt pin not gated");
  AST_RD_ANS: assert property (
    cmd_i.valid && cmd_i.opcode == MCR_RD_OP |=> rd_valid_o)
    else $error("read not answered");
  AST_START_OSC: assert property (
    st |-> fast_osc_en_o && busy_o)
    else $error("start without oscillator");
  AST_SETTLE: assert property (
    st && code_ff < SETTLE_ON |-> up_ff >= (NS[code_ff] - 1) * DIV)
    else $error("start before settling");
  AST_HALT: assert property (
    cmd_i.valid && cmd_i.opcode == OP_HALT |-> ##[1:3] !busy_o)
    else $error("halt ignored");
  AST_HALT_NOSTART: assert property (
    cmd_i.valid && cmd_i.opcode == OP_HALT |=> !st)
    else $error("sequence started by a halted command");
  cover property (st && code_ff < SETTLE_ON);
  cover property (temp_seq_start_o);
  cover property (cmd_i.valid && cmd_i.opcode == OP_HALT && busy_o);
endmodule
bind mcr_ctrl mcr_ctrl_checker #(.OP_HALT(OP_HALT), .IRQ_N(IRQ_N), .DIV(DIV))
  mcr_ctrl_checker_i (.ref_clk_i, .resetn_i, .cmd_i, .dir_up_i, .irq_src_i,
    .rd_valid_o, .comparator_direction_pin_o, .int_pin_o, .fast_osc_en_o,
    .flow_seq_start_o, .temp_seq_start_o, .busy_o);
`default_nettype wire

// [mcr_ctrl_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module mcr_ctrl_tb
  import mcr_pkg::*;
;
  localparam int D = 4; // short slow tick keeps the run brief
  localparam int NS [5] = '{16, 48, 96, 128, 168};
  logic        ref_clk, resetn, cmp_raw, dir_up, slow, done;
  logic        rd_valid, pin, int_pin, osc, f_st, t_st, busy, cyc_irq;
  logic [3:0]  irq_src;
  logic [15:0] rd_data;
  mcr_cmd_t    cmd;
  int          mismatches, num_checks, cyc, n_f, n_t;
  mcr_ctrl #(.DIV(D)) mcr_ctrl_i (.ref_clk_i(ref_clk), .resetn_i(resetn),
    .cmd_i(cmd), .cmp_raw_i(cmp_raw), .dir_up_i(dir_up),
    .irq_src_i(irq_src), .seq_done_i(done), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .comparator_direction_pin_o(pin),
    .int_pin_o(int_pin), .fast_osc_en_o(osc), .flow_seq_start_o(f_st),
    .temp_seq_start_o(t_st), .per_cycle_irq_o(cyc_irq), .busy_o(busy));
  mcr_eng_model mcr_eng_model_i (.ref_clk_i(ref_clk), .resetn_i(resetn),
    .start_i(f_st | t_st), .slow_i(slow), .seq_done_o(done));
  // ------------------------------
  // clock, pulse counters, hang guard
  // ------------------------------
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    n_f <= n_f + int'(f_st);
    n_t <= n_t + int'(t_st);
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // one-cycle command pulse, back at idle on return
  task automatic send(input logic [7:0] op, input logic [15:0] d);
    @(posedge ref_clk);
    cmd <= '{1'b1, op, d};
    @(posedge ref_clk);
    cmd.valid <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] exp);
    int k;
    send(MCR_RD_OP, 16'h0000);
    for (k = 0; k < 4 && rd_valid !== 1'b1; k++) @(posedge ref_clk);
    chk(rd_valid, 1'b1);
    chk(rd_data, exp);
  endtask
  task automatic t_regs();
    rd(16'h0000);
    chk(cyc_irq, 1'b0);
    send(MCR_WR_OP, 16'hffff);
    rd(16'h0fff);
    chk(cyc_irq, 1'b1);
  endtask
  task automatic t_pin();
    dir_up <= 1'b1;
    cmp_raw <= 1'b1;
    send(MCR_WR_OP, 16'h0400);
    repeat (6) @(posedge ref_clk);
    chk(pin, 1'b0);
    send(MCR_WR_OP, 16'h0c00);
    repeat (6) @(posedge ref_clk);
    chk(pin, 1'b1);
    cmp_raw <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(pin, 1'b0);
    send(MCR_WR_OP, 16'h0800);
    repeat (6) @(posedge ref_clk);
    chk(pin, 1'b1);
    dir_up <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(pin, 1'b0);
  endtask
  task automatic t_int();
    irq_src <= 4'h4;
    send(MCR_WR_OP, 16'h0000);
    repeat (4) @(posedge ref_clk);
    chk(int_pin, 1'b0);
    send(MCR_WR_OP, 16'h0200);
    repeat (4) @(posedge ref_clk);
    chk(int_pin, 1'b1);
    irq_src <= 4'h0;
    repeat (4) @(posedge ref_clk);
    chk(int_pin, 1'b0);
  endtask
  // single run; a second event command while busy must be dropped
  task automatic evt(input logic [7:0] op, input logic [2:0] c,
                     input int ef, input int et, input int lo, input int hi);
    int f0, t0, w, k;
    send(MCR_WR_OP, {9'h000, c, 4'h0});
    f0 = n_f;
    t0 = n_t;
    w = -1;
    send(op, 16'h0000);
    for (k = 0; k < 3000 && (busy === 1'b1 || k < 4); k++) begin
      @(posedge ref_clk);
      if (k == 1) cmd <= '{1'b1, (op == 8'h03) ? 8'h02 : 8'h03, 16'h0};
      if (k == 2) cmd.valid <= 1'b0;
      if (w < 0 && (f_st || t_st)) w = k;
    end
    @(posedge ref_clk);
    chk(16'(n_f - f0), 16'(ef));
    chk(16'(n_t - t0), 16'(et));
    chk(16'(w >= lo && w <= hi), 16'h1);
    chk(osc, c >= SETTLE_ON);
  endtask
  task automatic t_rep();
    int f0;
    send(MCR_WR_OP, 16'h0150);
    f0 = n_f;
    send(8'h02, 16'h0000);
    repeat (80) @(posedge ref_clk);
    chk(16'(n_f - f0 > 3), 16'h1);
    send(8'h04, 16'h0000);
    repeat (4) @(posedge ref_clk);
    chk(busy, 1'b0);
    f0 = n_f;
    repeat (40) @(posedge ref_clk);
    chk(16'(n_f - f0), 16'h0);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    cmp_raw = 1'b0;
    dir_up = 1'b0;
    slow = 1'b0;
    irq_src = 4'h0;
    cmd = '0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    t_regs();
    t_pin();
    t_int();
    for (int c = 0; c < 5; c++) begin
      evt(8'h02, 3'(c), 1, 0, NS[c] * D - D, NS[c] * D + D + 8);
    end
    evt(8'h01, 3'h5, 1, 1, 0, 8);
    slow <= 1'b1;
    evt(8'h01, 3'h1, 1, 1, NS[1] * D - D, NS[1] * D + D + 8);
    evt(8'h03, 3'h6, 0, 1, 0, 8);
    evt(8'h03, 3'h7, 0, 1, 0, 8);
    slow <= 1'b0;
    t_rep();
    end_sim();
  end
endmodule
`default_nettype wire

// [mcr_eng_model.sv]
`timescale 1ns/1ns
`default_nettype none
module mcr_eng_model (
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  input  wire logic start_i,
  input  wire logic slow_i,
  output logic      seq_done_o
);
  // ------------------------------
  // measurement engine stand-in
  // ------------------------------
  int cnt_ff;
  // slow answers let commands land while a sequence runs
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cnt_ff     <= 0;
      seq_done_o <= 1'b0;
    end else begin
      seq_done_o <= (cnt_ff == 1);
      if (start_i) cnt_ff <= slow_i ? 40 : 2;
      else if (cnt_ff > 0) cnt_ff <= cnt_ff - 1;
    end
  end
endmodule
`default_nettype wire

// [mcr_pkg.sv]
package mcr_pkg;

  // ----------------------------------------------------------------
  // register access over the serial command port
  // ----------------------------------------------------------------
  localparam logic [7:0]  MCR_WR_OP    = 8'h42;
  localparam logic [7:0]  MCR_RD_OP    = 8'hc2;
  localparam logic [15:0] MCR_RST_VAL  = 16'h0000;
  localparam logic [15:0] MCR_WR_MASK  = 16'h0fff; // 15:12 reserved

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PIN_EN_BIT   = 11;
  localparam int PIN_SEL_BIT  = 10;
  localparam int INT_EN_BIT   = 9;
  localparam int REPEAT_BIT   = 8;
  localparam int CYC_IRQ_BIT  = 7;
  localparam int SETTLE_MSB   = 6;
  localparam int SETTLE_LSB   = 4;

  // ----------------------------------------------------------------
  // settling codes and slow-clock cycle counts
  // ----------------------------------------------------------------
  localparam logic [2:0] SETTLE_C0  = 3'h0;
  localparam logic [2:0] SETTLE_C1  = 3'h1;
  localparam logic [2:0] SETTLE_C2  = 3'h2;
  localparam logic [2:0] SETTLE_C3  = 3'h3;
  localparam logic [2:0] SETTLE_C4  = 3'h4;
  localparam logic [2:0] SETTLE_ON  = 3'h5; // this code and above
  localparam logic [7:0] SETTLE_N0  = 8'h10; // 16
  localparam logic [7:0] SETTLE_N1  = 8'h30; // 48
  localparam logic [7:0] SETTLE_N2  = 8'h60; // 96
  localparam logic [7:0] SETTLE_N3  = 8'h80; // 128
  localparam logic [7:0] SETTLE_N4  = 8'ha8; // 168

  // ----------------------------------------------------------------
  // timing: slow tick derived from the reference clock
  // ----------------------------------------------------------------
  localparam int REF_HZ   = 20_000_000;
  localparam int SLOW_HZ  = 32_768;
  localparam int SLOW_DIV = REF_HZ / SLOW_HZ; // rounds down
  localparam int DIV_W    = $clog2(SLOW_DIV);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [15:0] data;
  } mcr_cmd_t;

  typedef enum logic [1:0] {
    KIND_BOTH,
    KIND_FLOW,
    KIND_TEMP
  } mcr_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_ISSUE,
    ST_WAIT
  } mcr_state_t;

endpackage

// [mcr_settle_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module mcr_settle_timer
  import mcr_pkg::*;
#(
  parameter int DIV = SLOW_DIV
) (
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic [2:0] code_i,
  output logic            done_o
);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [7:0]       cnt;
    logic             busy;
    logic             done;
  } mcr_tmr_st_t;

  mcr_tmr_st_t st_ff;
  mcr_tmr_st_t nxt_st;

  // ----------------------------------------------------------------
  // code to slow-cycle count
  // ----------------------------------------------------------------
  function automatic logic [7:0] settle_cycles(input logic [2:0] c);
    case (c)
      SETTLE_C0: settle_cycles = SETTLE_N0;
      SETTLE_C1: settle_cycles = SETTLE_N1;
      SETTLE_C2: settle_cycles = SETTLE_N2;
      SETTLE_C3: settle_cycles = SETTLE_N3;
      SETTLE_C4: settle_cycles = SETTLE_N4;
      default:   settle_cycles = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // divider and slow-cycle count
  // ----------------------------------------------------------------
  // divider restarts on start so the first slow cycle is a full one
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (abort_i) begin
      nxt_st.busy = 1'b0;
    end else if (start_i) begin
      nxt_st.div  = '0;
      nxt_st.cnt  = settle_cycles(code_i);
      nxt_st.busy = (code_i < SETTLE_ON);
      nxt_st.done = (code_i >= SETTLE_ON);
    end else if (st_ff.busy) begin
      if (st_ff.div == DIV_W'(DIV - 1)) begin
        nxt_st.div = '0;
        nxt_st.cnt = st_ff.cnt - 8'h01;
        if (st_ff.cnt == 8'h01) begin
          nxt_st.busy = 1'b0;
          nxt_st.done = 1'b1;
        end
      end else begin
        nxt_st.div = st_ff.div + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done_o = st_ff.done;

endmodule
`default_nettype wire
